// ### hw/tape_return_pkg.sv
/*
 * constants, modes and carriers for the tape controller return path
 * and maintenance test logic.
 * assumes a 40 MHz controller clock.
 */
package tape_return_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_KHZ      = 40000;
    localparam int TIME_A_MS    = 5;
    localparam int TIME_B_MS    = 10;
    localparam int TIME_C_MS    = 320;
    localparam int TIME_A_CYC   = TIME_A_MS * CLK_KHZ;
    localparam int TIME_B_CYC   = TIME_B_MS * CLK_KHZ;
    localparam int TIME_C_CYC   = TIME_C_MS * CLK_KHZ;
    localparam int CNT_W        = 24;

    // ****************************************
    // widths and fields
    // ****************************************
    localparam int DATA_W       = 7;
    localparam int INSTR_W      = 30;
    localparam int WC_W         = 9;
    localparam int WC_LSB       = 0;
    localparam int WC_MSB       = 8;

    // ****************************************
    // modes and selections
    // ****************************************
    typedef enum logic [1:0] {
        MODE_ONLINE     = 2'h0,
        MODE_OFFLINE    = 2'h1,
        MODE_CTRL_TEST  = 2'h2,
        MODE_XPORT_TEST = 2'h3
    } mode_t;

    typedef enum logic [1:0] {
        OPT_SINGLE   = 2'h0,
        OPT_REPEAT   = 2'h1,
        OPT_HALT_ERR = 2'h2
    } option_t;

    typedef enum logic [1:0] {
        SEQ_CONT         = 2'h0,
        SEQ_FWD_STOP     = 2'h1,
        SEQ_REV_STOP     = 2'h2,
        SEQ_FWD_STOP_REV = 2'h3
    } seq_t;

    typedef enum logic [1:0] {
        TSEL_A = 2'h0,
        TSEL_B = 2'h1,
        TSEL_C = 2'h2
    } tsel_t;

    typedef enum logic [2:0] {
        RUN_IDLE = 3'h1,
        RUN_BUSY = 3'h2,
        RUN_HALT = 3'h4
    } run_state_t;

    typedef enum logic [2:0] {
        TST_IDLE  = 3'h1,
        TST_DRIVE = 3'h2,
        TST_STOP  = 3'h4
    } tst_state_t;

    // ****************************************
    // transport status lines
    // ****************************************
    typedef struct packed {
        logic sel_ack;
        logic load_point;
        logic eot_warn;
        logic ready;
        logic rewinding;
        logic write_lockout;
        logic low_tape;
    } xport_stat_t;

endpackage

// ### hw/tape_transport_return_and_test.sv
/*
 * tape controller side of the transport return link, status gating,
 * select check, off-line panel sequencing, controller test stepping
 * and transport motion test.
 * assumes panel and sequencer inputs are synchronous to mclk_i;
 * transport lines are asynchronous and synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

module tape_transport_return_and_test #(
    parameter int TIME_A_CYC = tape_return_pkg::TIME_A_CYC,
    parameter int TIME_B_CYC = tape_return_pkg::TIME_B_CYC,
    parameter int TIME_C_CYC = tape_return_pkg::TIME_C_CYC
) (
    // clock and reset
    input  wire logic                                   mclk_i,
    input  wire logic                                   arst_n_i,
    // transport return lines
    input  wire logic [tape_return_pkg::DATA_W-1:0]     rd_data_i,
    input  wire logic                                   rd_strobe_i,
    input  wire tape_return_pkg::xport_stat_t           xport_stat_i,
    input  wire logic [1:0]                             tape_remain_i,
    // select toward the transport
    input  wire logic                                   select_req_i,
    output logic                                        select_o,
    // read data toward the controller
    output logic [tape_return_pkg::DATA_W-1:0]          rd_frame_o,
    output logic                                        rd_frame_valid_o,
    // status and ungated lines
    output tape_return_pkg::xport_stat_t                status_word_o,
    output logic                                        load_point_raw_o,
    output logic                                        ready_raw_o,
    output logic                                        write_lockout_raw_o,
    output logic [1:0]                                  tape_remain_o,
    output logic [2:0]                                  indicators_o,
    // select check
    input  wire logic                                   sel_check_i,
    input  wire logic                                   status_clear_i,
    output logic                                        fault_o,
    output logic                                        normal_cpl_o,
    // maintenance panel
    input  wire tape_return_pkg::mode_t                 mode_i,
    input  wire tape_return_pkg::option_t               option_i,
    input  wire logic                                   cycle_mode_i,
    input  wire logic [tape_return_pkg::INSTR_W-1:0]    panel_instr_i,
    input  wire logic                                   panel_load_i,
    input  wire logic                                   panel_start_i,
    input  wire logic                                   panel_step_i,
    input  wire logic [tape_return_pkg::INSTR_W-1:0]    panel_data_i,
    // sequencer handshake
    input  wire logic                                   word_done_i,
    input  wire logic                                   record_end_i,
    input  wire logic                                   file_mark_i,
    input  wire logic                                   instr_done_i,
    input  wire logic                                   instr_err_i,
    output logic [tape_return_pkg::INSTR_W-1:0]         instr_o,
    output logic                                        instr_start_o,
    output logic                                        read_reverse_o,
    output logic                                        offline_timing_err_o,
    output logic                                        run_halted_o,
    // controller test
    output logic                                        loop_gate_o,
    output logic                                        step_o,
    output logic [tape_return_pkg::INSTR_W-1:0]         test_data_o,
    // transport motion test
    input  wire logic                                   tt_start_i,
    input  wire logic                                   tt_stop_i,
    input  wire tape_return_pkg::seq_t                  tt_seq_i,
    input  wire tape_return_pkg::tsel_t                 drive_sel_i,
    input  wire tape_return_pkg::tsel_t                 stop_sel_i,
    input  wire logic                                   tt_write_i,
    output logic                                        tt_fwd_o,
    output logic                                        tt_rev_o,
    output logic                                        tt_write_o,
    output logic                                        tt_read_o
);

    // ****************************************
    // synchronisers
    // ****************************************
    logic [tape_return_pkg::DATA_W-1:0] data_s1_reg;
    logic [tape_return_pkg::DATA_W-1:0] data_s2_reg;
    logic                               strb_s1_reg;
    logic                               strb_s2_reg;
    logic                               strb_d_reg;
    tape_return_pkg::xport_stat_t       stat_s1_reg;
    tape_return_pkg::xport_stat_t       stat_s2_reg;
    logic [1:0]                         rem_s1_reg;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_s1_reg <= '0;
            data_s2_reg <= '0;
            strb_s1_reg <= 1'b0;
            strb_s2_reg <= 1'b0;
            strb_d_reg  <= 1'b0;
            stat_s1_reg <= '0;
            stat_s2_reg <= '0;
            rem_s1_reg  <= 2'h0;
        end else begin
            data_s1_reg <= rd_data_i;
            data_s2_reg <= data_s1_reg;
            strb_s1_reg <= rd_strobe_i;
            strb_s2_reg <= strb_s1_reg;
            strb_d_reg  <= strb_s2_reg;
            stat_s1_reg <= xport_stat_i;
            stat_s2_reg <= stat_s1_reg;
            rem_s1_reg  <= tape_remain_i;
        end
    end

    // ****************************************
    // read frame capture
    // ****************************************
    logic sel_reg;
    logic strb_rise;

    assign strb_rise = strb_s2_reg & ~strb_d_reg;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_reg          <= 1'b0;
            rd_frame_o       <= '0;
            rd_frame_valid_o <= 1'b0;
        end else begin
            sel_reg          <= select_req_i;
            rd_frame_valid_o <= strb_rise & sel_reg;
            if (strb_rise && sel_reg) begin
                rd_frame_o <= data_s2_reg;
            end
        end
    end

    assign select_o = sel_reg;

    // ****************************************
    // status word and ungated lines
    // ****************************************
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_word_o       <= '0;
            load_point_raw_o    <= 1'b0;
            ready_raw_o         <= 1'b0;
            write_lockout_raw_o <= 1'b0;
            tape_remain_o       <= 2'h0;
            indicators_o        <= 3'h0;
        end else begin
            status_word_o       <= sel_reg ? stat_s2_reg : '0;
            load_point_raw_o    <= stat_s2_reg.load_point;
            ready_raw_o         <= stat_s2_reg.ready;
            write_lockout_raw_o <= stat_s2_reg.write_lockout;
            tape_remain_o       <= rem_s1_reg;
            indicators_o        <= {stat_s2_reg.ready, stat_s2_reg.load_point,
                                    stat_s2_reg.write_lockout};
        end
    end

    // ****************************************
    // select check
    // ****************************************
    logic sel_fail;

    assign sel_fail = sel_check_i & sel_reg & ~(stat_s2_reg.sel_ack & stat_s2_reg.ready);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_o      <= 1'b0;
            normal_cpl_o <= 1'b1;
        end else begin
            if (sel_fail) begin
                fault_o      <= 1'b1;
                normal_cpl_o <= 1'b0;
            end else if (status_clear_i) begin
                fault_o      <= 1'b0;
                normal_cpl_o <= 1'b1;
            end
        end
    end

    // ****************************************
    // off-line instruction and word count
    // ****************************************
    logic                            maint_en;
    logic                            offline;
    logic [tape_return_pkg::WC_W-1:0] words_reg;

    assign maint_en = (mode_i != tape_return_pkg::MODE_ONLINE);
    assign offline  = (mode_i == tape_return_pkg::MODE_OFFLINE);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            instr_o <= '0;
        end else if (offline && panel_load_i) begin
            instr_o <= panel_instr_i;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            words_reg            <= '0;
            offline_timing_err_o <= 1'b0;
        end else begin
            if (!offline || record_end_i) begin
                words_reg <= '0;
            end else if (word_done_i) begin
                words_reg <= words_reg + 1'b1;
            end
            if (offline && record_end_i &&
                words_reg != instr_o[tape_return_pkg::WC_MSB:tape_return_pkg::WC_LSB]) begin
                offline_timing_err_o <= 1'b1;
            end else if (status_clear_i || (offline && panel_load_i)) begin
                offline_timing_err_o <= 1'b0;
            end
        end
    end

    // ****************************************
    // panel run sequencing
    // ****************************************
    tape_return_pkg::run_state_t run_reg;
    logic                        run_err;
    logic                        cyc_last;

    assign run_err  = instr_err_i | offline_timing_err_o;
    assign cyc_last = ~cycle_mode_i | read_reverse_o;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_reg        <= tape_return_pkg::RUN_IDLE;
            instr_start_o  <= 1'b0;
            read_reverse_o <= 1'b0;
        end else begin
            instr_start_o <= 1'b0;
            case (run_reg)
                tape_return_pkg::RUN_IDLE: begin
                    read_reverse_o <= 1'b0;
                    if (offline && panel_start_i) begin
                        instr_start_o <= 1'b1;
                        run_reg       <= tape_return_pkg::RUN_BUSY;
                    end
                end
                tape_return_pkg::RUN_BUSY: begin
                    if (!offline) begin
                        run_reg <= tape_return_pkg::RUN_IDLE;
                    end else if (cycle_mode_i && file_mark_i && !read_reverse_o) begin
                        read_reverse_o <= 1'b1;
                    end else if (instr_done_i || (cycle_mode_i && file_mark_i)) begin
                        if (option_i == tape_return_pkg::OPT_HALT_ERR && run_err) begin
                            run_reg <= tape_return_pkg::RUN_HALT;
                        end else if (option_i == tape_return_pkg::OPT_SINGLE &&
                                     (cyc_last || !file_mark_i)) begin
                            run_reg <= tape_return_pkg::RUN_IDLE;
                        end else if (cycle_mode_i && file_mark_i) begin
                            read_reverse_o <= 1'b0;
                            instr_start_o  <= 1'b1;
                        end else begin
                            instr_start_o <= 1'b1;
                        end
                    end
                end
                tape_return_pkg::RUN_HALT: begin
                    if (!offline || panel_start_i) begin
                        run_reg <= tape_return_pkg::RUN_IDLE;
                    end
                end
                default: begin
                    run_reg <= tape_return_pkg::RUN_IDLE;
                end
            endcase
        end
    end

    assign run_halted_o = (run_reg == tape_return_pkg::RUN_HALT);

    // ****************************************
    // controller test
    // ****************************************
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            loop_gate_o <= 1'b0;
            step_o      <= 1'b0;
            test_data_o <= '0;
        end else begin
            loop_gate_o <= (mode_i == tape_return_pkg::MODE_CTRL_TEST);
            step_o      <= (mode_i == tape_return_pkg::MODE_CTRL_TEST) & panel_step_i;
            test_data_o <= maint_en ? panel_data_i : '0;
        end
    end

    // ****************************************
    // transport motion test
    // ****************************************
    function automatic logic [tape_return_pkg::CNT_W-1:0] sel_time(
        input tape_return_pkg::tsel_t s
    );
        case (s)
            tape_return_pkg::TSEL_A: sel_time = tape_return_pkg::CNT_W'(TIME_A_CYC);
            tape_return_pkg::TSEL_B: sel_time = tape_return_pkg::CNT_W'(TIME_B_CYC);
            default:                 sel_time = tape_return_pkg::CNT_W'(TIME_C_CYC);
        endcase
    endfunction

    tape_return_pkg::tst_state_t          tst_reg;
    logic [tape_return_pkg::CNT_W-1:0]    tcnt_reg;
    logic                                 tt_en;
    logic                                 eot_fwd;

    assign tt_en   = (mode_i == tape_return_pkg::MODE_XPORT_TEST);
    assign eot_fwd = tt_fwd_o & stat_s2_reg.eot_warn;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tst_reg    <= tape_return_pkg::TST_IDLE;
            tcnt_reg   <= '0;
            tt_fwd_o   <= 1'b0;
            tt_rev_o   <= 1'b0;
            tt_write_o <= 1'b0;
            tt_read_o  <= 1'b0;
        end else begin
            case (tst_reg)
                tape_return_pkg::TST_IDLE: begin
                    tt_fwd_o   <= 1'b0;
                    tt_rev_o   <= 1'b0;
                    tt_write_o <= 1'b0;
                    tt_read_o  <= 1'b0;
                    if (tt_en && tt_start_i) begin
                        tst_reg    <= tape_return_pkg::TST_DRIVE;
                        tcnt_reg   <= sel_time(drive_sel_i) - 1'b1;
                        tt_fwd_o   <= (tt_seq_i != tape_return_pkg::SEQ_REV_STOP);
                        tt_rev_o   <= (tt_seq_i == tape_return_pkg::SEQ_REV_STOP);
                        tt_write_o <= tt_write_i;
                        tt_read_o  <= 1'b1;
                    end
                end
                tape_return_pkg::TST_DRIVE: begin
                    if (!tt_en || tt_stop_i || eot_fwd) begin
                        tst_reg <= tape_return_pkg::TST_IDLE;
                    end else if (tt_seq_i == tape_return_pkg::SEQ_CONT) begin
                        tcnt_reg <= tcnt_reg;
                    end else if (tcnt_reg == '0) begin
                        tst_reg  <= tape_return_pkg::TST_STOP;
                        tcnt_reg <= sel_time(stop_sel_i) - 1'b1;
                        tt_fwd_o <= 1'b0;
                        tt_rev_o <= 1'b0;
                    end else begin
                        tcnt_reg <= tcnt_reg - 1'b1;
                    end
                end
                tape_return_pkg::TST_STOP: begin
                    if (!tt_en || tt_stop_i) begin
                        tst_reg <= tape_return_pkg::TST_IDLE;
                    end else if (tcnt_reg == '0) begin
                        tst_reg  <= tape_return_pkg::TST_DRIVE;
                        tcnt_reg <= sel_time(drive_sel_i) - 1'b1;
                        case (tt_seq_i)
                            tape_return_pkg::SEQ_REV_STOP: begin
                                tt_rev_o <= 1'b1;
                            end
                            tape_return_pkg::SEQ_FWD_STOP_REV: begin
                                tt_fwd_o <= tt_rev_o ? 1'b1 : 1'b0;
                                tt_rev_o <= ~tt_rev_o;
                            end
                            default: begin
                                tt_fwd_o <= 1'b1;
                            end
                        endcase
                    end else begin
                        tcnt_reg <= tcnt_reg - 1'b1;
                    end
                end
                default: begin
                    tst_reg <= tape_return_pkg::TST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### test/tape_return_monitor.sv
/* port assertions for the tape return block; bound to the design top, one clock domain */
`timescale 1ns/1ps
`default_nettype none
module tape_return_monitor (
    // clock, reset, status
    input wire logic mclk_i, arst_n_i, select_o, fault_o, normal_cpl_o, status_clear_i, rd_frame_valid_o,
    input wire tape_return_pkg::xport_stat_t status_word_o,
    input wire logic [1:0] tape_remain_i, tape_remain_o,
    // panel and test
    input wire tape_return_pkg::mode_t mode_i,
    input wire logic panel_load_i, panel_step_i, step_o, loop_gate_o, instr_start_o,
    input wire logic [29:0] panel_instr_i, instr_o,
    input wire logic tt_start_i, tt_fwd_o, tt_rev_o, tt_read_o,
    input wire tape_return_pkg::seq_t tt_seq_i
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    a_unsel_status_zero: assert property (!select_o [*3] |-> status_word_o == '0)
        else $error("status shown while unselected");
    a_frame_one_pulse: assert property (rd_frame_valid_o |=> !rd_frame_valid_o)
        else $error("frame valid longer than one cycle");
    a_fault_clears_cpl: assert property ($rose(fault_o) |-> !normal_cpl_o)
        else $error("fault without completion cleared");
    a_fault_holds: assert property (fault_o && !status_clear_i |=> fault_o)
        else $error("fault dropped without clear");
    a_remain_ungated: assert property ($past(arst_n_i, 2) |-> tape_remain_o == $past(tape_remain_i, 2))
        else $error("tape remaining not passed through");
    a_online_no_panel: assert property (mode_i == tape_return_pkg::MODE_ONLINE
        && $past(mode_i) == tape_return_pkg::MODE_ONLINE |-> !instr_start_o && !step_o && !loop_gate_o)
        else $error("panel acted while on-line");
    a_offline_load: assert property (mode_i == tape_return_pkg::MODE_OFFLINE && panel_load_i
        |=> instr_o == $past(panel_instr_i))
        else $error("panel word not loaded");
    a_step_ctrl: assert property (mode_i == tape_return_pkg::MODE_CTRL_TEST && panel_step_i |=> step_o && loop_gate_o)
        else $error("step not taken");
    a_tt_start_fwd: assert property (mode_i == tape_return_pkg::MODE_XPORT_TEST && tt_start_i && !tt_read_o
        && tt_seq_i != tape_return_pkg::SEQ_REV_STOP |=> tt_fwd_o && tt_read_o)
        else $error("transport test did not drive forward");
    cover property (rd_frame_valid_o);
    cover property ($rose(fault_o));
    cover property ($rose(tt_rev_o));
endmodule
bind tape_transport_return_and_test tape_return_monitor u_mon (.*);
`default_nettype wire

// ### test/tape_xport_model.sv
/* transport model on the far side: frames, status lines, tape remaining; steered by the bench */
`timescale 1ns/1ps
`default_nettype none
module tape_xport_model (
    input  wire logic                    select_i,
    output logic [6:0]                   rd_data_o,
    output logic                         rd_strobe_o,
    output tape_return_pkg::xport_stat_t stat_o,
    output logic [1:0]                   remain_o
);
    logic       mute = 1'b0;
    logic [5:0] lines = '0;
    assign stat_o = {select_i & ~mute, lines};
    initial begin
        rd_data_o = '0;
        rd_strobe_o = 1'b0;
        remain_o = '0;
    end
    task automatic frame(input logic [6:0] d);
        rd_data_o = d;
        #100 rd_strobe_o = 1'b1;
        #2000 rd_strobe_o = 1'b0;
        #2000 rd_data_o = ~d;
    endtask
endmodule
`default_nettype wire

// ### test/tb_tape_transport_return_and_test.sv
/* self-checking bench for the tape return block; transport model on the far side, 40 MHz clock */
`timescale 1ns/1ps
`default_nettype none
module tb_tape_transport_return_and_test;
    logic mclk_i = 0, arst_n_i = 0, select_req_i = 0, sel_check_i = 0, status_clear_i = 0, cycle_mode_i = 0;
    logic panel_load_i = 0, panel_start_i = 0, panel_step_i = 0, word_done_i = 0, record_end_i = 0;
    logic file_mark_i = 0, instr_done_i = 0, instr_err_i = 0, tt_start_i = 0, tt_stop_i = 0, tt_write_i = 1;
    logic [29:0] panel_instr_i = '0, panel_data_i = '0, last;
    tape_return_pkg::mode_t mode_i = tape_return_pkg::MODE_ONLINE;
    tape_return_pkg::option_t option_i = tape_return_pkg::OPT_SINGLE;
    tape_return_pkg::seq_t tt_seq_i = tape_return_pkg::SEQ_FWD_STOP_REV;
    tape_return_pkg::tsel_t drive_sel_i = tape_return_pkg::TSEL_A, stop_sel_i = tape_return_pkg::TSEL_B;
    wire logic [6:0] rd_data_i;
    wire logic rd_strobe_i;
    wire tape_return_pkg::xport_stat_t xport_stat_i;
    wire logic [1:0] tape_remain_i;
    logic select_o, rd_frame_valid_o, load_point_raw_o, ready_raw_o, write_lockout_raw_o, fault_o, normal_cpl_o;
    logic instr_start_o, read_reverse_o, offline_timing_err_o, run_halted_o, loop_gate_o, step_o;
    logic tt_fwd_o, tt_rev_o, tt_write_o, tt_read_o;
    tape_return_pkg::xport_stat_t status_word_o;
    logic [6:0] rd_frame_o, q[$];
    logic [5:0] e;
    logic [1:0] tape_remain_o;
    logic [2:0] indicators_o;
    logic [29:0] instr_o, test_data_o;
    int err_count = 0, checks_done = 0, n;
    tape_transport_return_and_test #(.TIME_A_CYC(8), .TIME_B_CYC(16), .TIME_C_CYC(32)) u_dut (.*);
    tape_xport_model u_tt (.select_i(select_o), .rd_data_o(rd_data_i), .rd_strobe_o(rd_strobe_i),
        .stat_o(xport_stat_i), .remain_o(tape_remain_i));
    always #12.5 mclk_i = ~mclk_i;
    task automatic chk(input logic [63:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge mclk_i);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        if (rd_frame_valid_o === 1'b1) begin
            chk(q.size() != 0, 1);
            if (q.size() != 0) chk(rd_frame_o, q.pop_front());
        end
    end
    // watchdog: the tests need well under 200 us
    initial begin
        #500us;
        err_count++;
        complete_run;
    end
    initial begin
        void'($urandom(4832));
        tick(8);
        arst_n_i <= 1'b1;
        tick(2);
        chk({fault_o, normal_cpl_o}, 2'b01);
        u_tt.frame(7'h55);
        select_req_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            n = $urandom;
            q.push_back(n[6:0]);
            u_tt.frame(n[6:0]);
        end
        tick(8);
        chk(q.size(), 0);
        for (int i = 0; i < 3; i++) begin
            n = $urandom;
            e = n[5:0] & 6'h2F;
            u_tt.lines <= e;
            u_tt.remain_o <= n[8:7];
            tick(5);
            chk(status_word_o, {1'b1, e});
            chk({indicators_o, tape_remain_o}, {e[3], e[5], e[1], n[8:7]});
        end
        select_req_i <= 1'b0;
        tick(5);
        chk({status_word_o, load_point_raw_o, ready_raw_o, write_lockout_raw_o}, {7'h00, e[5], e[3], e[1]});
        u_tt.mute <= 1'b1;
        select_req_i <= 1'b1;
        tick(4);
        sel_check_i <= 1'b1;
        tick(1);
        sel_check_i <= 1'b0;
        tick(2);
        chk({fault_o, normal_cpl_o}, 2'b10);
        status_clear_i <= 1'b1;
        tick(1);
        status_clear_i <= 1'b0;
        u_tt.mute <= 1'b0;
        tick(2);
        chk(fault_o, 0);
        $display("test return path done");
        mode_i <= tape_return_pkg::MODE_OFFLINE;
        for (int w = 2; w < 4; w++) begin
            n = $urandom;
            last = {n[20:0], 9'h003};
            panel_instr_i <= last;
            panel_load_i <= 1'b1;
            tick(1);
            panel_load_i <= 1'b0;
            tick(1);
            chk(instr_o, last);
            word_done_i <= 1'b1;
            tick(w);
            word_done_i <= 1'b0;
            record_end_i <= 1'b1;
            tick(1);
            record_end_i <= 1'b0;
            tick(2);
            chk(offline_timing_err_o, w != 3);
        end
        cycle_mode_i <= 1'b1;
        panel_start_i <= 1'b1;
        tick(1);
        panel_start_i <= 1'b0;
        file_mark_i <= 1'b1;
        tick(2);
        chk(read_reverse_o, 1);
        file_mark_i <= 1'b0;
        option_i <= tape_return_pkg::OPT_HALT_ERR;
        panel_start_i <= 1'b1;
        tick(1);
        panel_start_i <= 1'b0;
        tick(1);
        chk({instr_start_o, read_reverse_o}, 2'b10);
        instr_done_i <= 1'b1;
        instr_err_i <= 1'b1;
        tick(1);
        instr_done_i <= 1'b0;
        tick(2);
        chk(run_halted_o, 1);
        mode_i <= tape_return_pkg::MODE_ONLINE;
        panel_instr_i <= ~last;
        panel_data_i <= last;
        panel_load_i <= 1'b1;
        tick(1);
        panel_load_i <= 1'b0;
        tick(2);
        chk({instr_o, test_data_o}, {last, 30'h0});
        mode_i <= tape_return_pkg::MODE_CTRL_TEST;
        panel_step_i <= 1'b1;
        tick(1);
        panel_step_i <= 1'b0;
        tick(1);
        chk({loop_gate_o, step_o, test_data_o}, {2'b11, last});
        $display("test panel modes done");
        mode_i <= tape_return_pkg::MODE_XPORT_TEST;
        tt_start_i <= 1'b1;
        tick(1);
        tt_start_i <= 1'b0;
        tick(1);
        chk({tt_fwd_o, tt_read_o, tt_write_o}, 3'b111);
        n = 0;
        while (tt_fwd_o === 1'b1 && n < 99) begin
            tick(1);
            n++;
        end
        chk(n, 8);
        n = 0;
        while (tt_rev_o !== 1'b1 && n < 99) begin
            tick(1);
            n++;
        end
        chk(n, 16);
        tt_stop_i <= 1'b1;
        tt_seq_i <= tape_return_pkg::SEQ_CONT;
        tick(1);
        tt_stop_i <= 1'b0;
        tick(3);
        tt_start_i <= 1'b1;
        tick(1);
        tt_start_i <= 1'b0;
        tick(40);
        chk(tt_fwd_o, 1);
        u_tt.lines <= 6'h18;
        tick(8);
        chk(tt_fwd_o, 0);
        $display("test transport motion done");
        complete_run;
    end
endmodule
`default_nettype wire
